// [core/rst_defs.svh]
`ifndef RST_DEFS_SVH
`define RST_DEFS_SVH

`define PSC_ADDR        8'hFF
`define IRQ_STAT_ADDR   8'hFD
`define IRQ_MASK_ADDR   8'hFE
`define CLK_CFG_ADDR    8'hFC
`define PSC_RESET       8'h10
`define PSC_BIT_IRQEN   7
`define PSC_BIT_WATCHDOG_RESET_FLAG    5
`define PSC_BIT_POWER_ON_RESET_FLAG    4
`define PSC_BIT_SLEEP   3
`define PSC_BIT_STOP    0
`define RESET_VECTOR    16'h0000
`define CLK_DIV_POR     3'h3
`define CLK_INTERNAL    1'b0
`define SLEEP_IVL_MIN   2'h0
`define CLK_MHZ         50
`define EXTERNAL_RESET_PIN_MIN_NS     10000
`define EXTERNAL_RESET_PIN_MIN_CYC    ((`EXTERNAL_RESET_PIN_MIN_NS * `CLK_MHZ + 999) / 1000)
`define POR_HOLD_MS     64
`define POR_HOLD_CYC    (`POR_HOLD_MS * 1000 * `CLK_MHZ)

`endif

// [core/rst_pkg.sv]
package rst_pkg;
  typedef enum logic [2:0] {
    ST_HOLD  = 3'b001,
    ST_RUN   = 3'b010,
    ST_SLEEP = 3'b100
  } cpu_state_e;
endpackage

// [core/external_reset_pin_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface external_reset_pin_if;
  logic pin;
  logic fire;
  modport filt (input pin, output fire);
  modport top (output pin, input fire);
endinterface
`default_nettype wire

// [core/external_reset_pin_filter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rst_defs.svh"
module external_reset_pin_filter #(
  parameter int MIN_CYC = `EXTERNAL_RESET_PIN_MIN_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  external_reset_pin_if.filt      xr
);
  initial begin
    if (MIN_CYC < 1 || MIN_CYC > 65535) $error("external_reset_pin_filter: bad MIN_CYC");
  end
  typedef struct packed {
    logic [15:0] cnt;
    logic        fire;
  } filt_s;
  filt_s st_r;
  filt_s st_nxt;
  always_comb begin
    st_nxt = st_r;
    st_nxt.fire = 1'b0;
    if (!xr.pin) begin
      st_nxt.cnt = 16'h0000;
    end else if (st_r.cnt < 16'(MIN_CYC)) begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
      st_nxt.fire = (st_r.cnt == 16'(MIN_CYC - 1));
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign xr.fire = st_r.fire;
endmodule // external_reset_pin_filter
`default_nettype wire

// [core/reset_cause_status_control.sv]
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "rst_defs.svh"
module reset_cause_status_control #(
  parameter int POR_HOLD_CYC = `POR_HOLD_CYC,
  parameter int EXTERNAL_RESET_PIN_CYC     = `EXTERNAL_RESET_PIN_MIN_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        external_reset_pin,
  input  wire logic        watchdog_reset_event,
  input  wire logic        global_irq_enable_view,
  input  wire logic        irq_pending,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             cpu_run,
  output logic             cpu_reset,
  output logic      [15:0] fetch_addr,
  output logic             irq_force_off,
  output logic             clk_source,
  output logic      [2:0]  cpu_clk_div,
  output logic      [1:0]  sleep_interval,
  output logic             wdt_enable,
  output logic             irq
);
  initial begin
    if (POR_HOLD_CYC < 1 || POR_HOLD_CYC > 2**30) $error("bad POR_HOLD_CYC");
  end

  typedef struct packed {
    rst_pkg::cpu_state_e state;
    logic [29:0]         hold_cnt;
    logic                watchdog_reset_flag;
    logic                power_on_reset_flag;
    logic                sleep;
    logic                stop;
    logic [2:0]          clk_div;
    logic                clk_src;
    logic [1:0]          sleep_ivl;
    logic [1:0]          irq_stat;
    logic [1:0]          irq_mask;
    logic [7:0]          rdata;
    logic                rst_pulse;
  } top_s;

  top_s st_r;
  top_s st_nxt;
  logic external_reset_pin_fire;
  logic psc_wr;
  logic [7:0] psc_view;

  external_reset_pin_if xr ();
  assign xr.pin = external_reset_pin;
  assign external_reset_pin_fire = xr.fire;

  external_reset_pin_filter #(
    .MIN_CYC (EXTERNAL_RESET_PIN_CYC)
  ) u_external_reset_pin (
    .clk_sys (clk_sys),
    .rst     (rst),
    .xr      (xr)
  );

  assign psc_wr = reg_wr && (reg_addr == `PSC_ADDR);

  always_comb begin
    psc_view = 8'h00;
    psc_view[`PSC_BIT_IRQEN] = global_irq_enable_view;
    psc_view[`PSC_BIT_WATCHDOG_RESET_FLAG]  = st_r.watchdog_reset_flag;
    psc_view[`PSC_BIT_POWER_ON_RESET_FLAG]  = st_r.power_on_reset_flag;
    psc_view[`PSC_BIT_SLEEP] = st_r.sleep;
    psc_view[`PSC_BIT_STOP]  = st_r.stop;
  end

  always_comb begin
    logic wdr_ok;
    wdr_ok = watchdog_reset_event && !st_r.power_on_reset_flag;
    st_nxt = st_r;
    st_nxt.rst_pulse = 1'b0;
    st_nxt.rdata = 8'h00;
    // Register writes
    if (psc_wr) begin
      if (!reg_wdata[`PSC_BIT_WATCHDOG_RESET_FLAG]) begin
        st_nxt.watchdog_reset_flag = 1'b0;
      end
      if (!reg_wdata[`PSC_BIT_POWER_ON_RESET_FLAG]) begin
        st_nxt.power_on_reset_flag = 1'b0;
      end
      st_nxt.sleep = reg_wdata[`PSC_BIT_SLEEP];
      st_nxt.stop  = reg_wdata[`PSC_BIT_STOP];
    end
    if (reg_wr && reg_addr == `CLK_CFG_ADDR) begin
      st_nxt.clk_div   = reg_wdata[2:0];
      st_nxt.clk_src   = reg_wdata[3];
      st_nxt.sleep_ivl = reg_wdata[5:4];
    end
    if (reg_wr && reg_addr == `IRQ_STAT_ADDR) begin
      st_nxt.irq_stat = st_r.irq_stat & ~reg_wdata[1:0];
    end
    if (reg_wr && reg_addr == `IRQ_MASK_ADDR) begin
      st_nxt.irq_mask = reg_wdata[1:0];
    end
    // Hold, run and sleep sequencing
    unique case (st_r.state)
      rst_pkg::ST_HOLD: begin
        if (st_r.hold_cnt == 30'(POR_HOLD_CYC - 1)) begin
          st_nxt.state = rst_pkg::ST_RUN;
          st_nxt.hold_cnt = 30'h0;
        end else begin
          st_nxt.hold_cnt = st_r.hold_cnt + 30'h1;
        end
      end
      rst_pkg::ST_RUN: begin
        if (st_r.sleep && irq_pending) begin
          st_nxt.sleep = 1'b0;
        end else if (st_r.sleep) begin
          st_nxt.state = rst_pkg::ST_SLEEP;
        end
      end
      rst_pkg::ST_SLEEP: begin
        if (irq_pending) begin
          st_nxt.state = rst_pkg::ST_RUN;
          st_nxt.sleep = 1'b0;
        end
      end
      default: st_nxt.state = rst_pkg::ST_HOLD;
    endcase
    // Reset sources
    if (external_reset_pin_fire) begin
      st_nxt = '0;
      st_nxt.state = rst_pkg::ST_HOLD;
      st_nxt.power_on_reset_flag = 1'b1;
      st_nxt.clk_div = `CLK_DIV_POR;
      st_nxt.irq_stat = 2'b01;
      st_nxt.rst_pulse = 1'b1;
    end else if (wdr_ok) begin
      st_nxt.watchdog_reset_flag = 1'b1;
      st_nxt.stop = 1'b0;
      st_nxt.sleep = 1'b0;
      st_nxt.state = rst_pkg::ST_RUN;
      st_nxt.clk_src = `CLK_INTERNAL;
      st_nxt.sleep_ivl = `SLEEP_IVL_MIN;
      st_nxt.irq_stat = st_nxt.irq_stat | 2'b10;
      st_nxt.rst_pulse = 1'b1;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `PSC_ADDR:      st_nxt.rdata = psc_view;
        `CLK_CFG_ADDR:  st_nxt.rdata = {2'b00, st_r.sleep_ivl, st_r.clk_src, st_r.clk_div};
        `IRQ_STAT_ADDR: st_nxt.rdata = {6'h00, st_r.irq_stat};
        `IRQ_MASK_ADDR: st_nxt.rdata = {6'h00, st_r.irq_mask};
        default:        st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.state <= rst_pkg::ST_HOLD;
      st_r.power_on_reset_flag <= 1'b1;
      st_r.clk_div <= `CLK_DIV_POR;
      st_r.clk_src <= `CLK_INTERNAL;
      st_r.sleep_ivl <= `SLEEP_IVL_MIN;
      st_r.irq_stat <= 2'b01;
      st_r.rst_pulse <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata      = st_r.rdata;
  assign cpu_run        = (st_r.state == rst_pkg::ST_RUN) && !st_r.stop && !st_r.rst_pulse;
  assign cpu_reset      = st_r.rst_pulse || (st_r.state == rst_pkg::ST_HOLD);
  assign fetch_addr     = `RESET_VECTOR;
  assign irq_force_off  = cpu_reset;
  assign clk_source     = st_r.clk_src;
  assign cpu_clk_div    = st_r.clk_div;
  assign sleep_interval = st_r.sleep_ivl;
  assign wdt_enable     = !st_r.power_on_reset_flag;
  assign irq            = |(st_r.irq_stat & st_r.irq_mask);
endmodule // reset_cause_status_control
`default_nettype wire

// [tb/rst_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module rst_monitor #(
  parameter int POR_HOLD_CYC = 20
) (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        watchdog_reset_event,
  input wire logic        global_irq_enable_view,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        cpu_run,
  input wire logic        cpu_reset,
  input wire logic [15:0] fetch_addr,
  input wire logic        irq_force_off,
  input wire logic        clk_source,
  input wire logic [2:0]  cpu_clk_div,
  input wire logic [1:0]  sleep_interval,
  input wire logic        wdt_enable
);
  int hold_cnt_r;
  // Length of the current processor hold
  always_ff @(posedge clk_sys or posedge rst)
    if (rst) hold_cnt_r <= 0;
    else hold_cnt_r <= cpu_reset ? hold_cnt_r + 1 : 0;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  fetch_zero_a: assert property (fetch_addr == 16'h0000)
    else $error("fetch not zero");
  irq_off_a: assert property (irq_force_off == cpu_reset)
    else $error("irq not off");
  irq_view_a: assert property (reg_rd && reg_addr == 8'hFF |=>
    reg_rdata[7] == $past(global_irq_enable_view)) else $error("bad view");
  wdt_gate_a: assert property (cpu_run && watchdog_reset_event && !wdt_enable |=> cpu_run)
    else $error("early watchdog");
  wdt_reset_a: assert property (watchdog_reset_event && wdt_enable |=> cpu_reset)
    else $error("no watchdog reset");
  reset_clock_a: assert property ($rose(cpu_reset) |-> !clk_source && sleep_interval == 2'h0)
    else $error("bad clock reset");
  div_por_a: assert property ($fell(rst) |-> cpu_clk_div == 3'h3 && cpu_reset && !cpu_run)
    else $error("bad power-on state");
  hold_len_a: assert property ($fell(cpu_reset) |-> hold_cnt_r == 1 ||
    (hold_cnt_r >= POR_HOLD_CYC && hold_cnt_r <= POR_HOLD_CYC + 16)) else $error("bad hold");
endmodule // rst_monitor
bind reset_cause_status_control rst_monitor #(.POR_HOLD_CYC(POR_HOLD_CYC)) i_rst_monitor (.*);
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_sys = 1'b0, rst = 1'b1, external_reset_pin = 1'b0, reg_wr = 1'b0;
  logic        watchdog_reset_event = 1'b0, global_irq_enable_view = 1'b0, irq_pending = 1'b0;
  logic        reg_rd = 1'b0, cpu_run, cpu_reset, irq_force_off, clk_source, wdt_enable, irq;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [15:0] fetch_addr;
  logic [2:0]  cpu_clk_div;
  logic [1:0]  sleep_interval;
  int          failures = 0, n_tests = 0;
  reset_cause_status_control #(.POR_HOLD_CYC(20), .EXTERNAL_RESET_PIN_CYC(4)) i_reset_cause_status_control (.*);
  always #10 clk_sys = ~clk_sys;
  task automatic test_done;
    if (failures == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    chk(reg_rdata, exp);
  endtask
  task automatic wait_run(input logic v);
    for (int i = 0; i < 60 && cpu_run !== v; i++) @(posedge clk_sys);
    #1;
    chk(cpu_run, v);
    if (cpu_run !== v) test_done;
  endtask
  task automatic pulse_wd;
    @(posedge clk_sys);
    watchdog_reset_event <= 1'b1;
    tick(1);
    watchdog_reset_event <= 1'b0;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd(8'hFF, 8'h10);
    rd(8'hFC, 8'h03);
    chk(fetch_addr, 16'h0000);
    wait_run(1'b1);
    global_irq_enable_view <= 1'b1;
    pulse_wd;
    tick(2);
    chk(cpu_run, 1'b1);
    wr(8'hFF, 8'h36);
    rd(8'hFF, 8'h90);
    wr(8'hFF, 8'h00);
    rd(8'hFF, 8'h80);
    chk(wdt_enable, 1'b1);
    wr(8'hFC, 8'h3F);
    wr(8'h01, 8'hFF);
    rd(8'h01, 8'h00);
    pulse_wd;
    chk(cpu_reset, 1'b1);
    wait_run(1'b1);
    rd(8'hFF, 8'hA0);
    rd(8'hFC, 8'h07);
    wr(8'hFE, 8'h02);
    tick(1);
    chk(irq, 1'b1);
    wr(8'hFD, 8'h02);
    tick(1);
    chk(irq, 1'b0);
    wr(8'hFF, 8'h08);
    tick(2);
    chk(cpu_run, 1'b0);
    irq_pending <= 1'b1;
    wait_run(1'b1);
    irq_pending <= 1'b0;
    rd(8'hFF, 8'h80);
    wr(8'hFF, 8'h01);
    irq_pending <= 1'b1;
    tick(4);
    chk(cpu_run, 1'b0);
    irq_pending <= 1'b0;
    pulse_wd;
    wait_run(1'b1);
    rd(8'hFF, 8'hA0);
    external_reset_pin <= 1'b1;
    tick(8);
    external_reset_pin <= 1'b0;
    tick(1);
    chk(cpu_reset, 1'b1);
    wait_run(1'b1);
    rd(8'hFF, 8'h90);
    rd(8'hFC, 8'h03);
    rd(8'hFE, 8'h00);
    test_done;
  end
endmodule // tb
`default_nettype wire
